// ==== hw/id_input_sampler.sv ====
// id input sampler: synchronises the id pins and detects code changes
// assumes pins are asynchronous to clk
`timescale 1ns/1ps
module id_input_sampler (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [4:0] id_pins,
	input wire logic sixth_id_input,
	id_link_if.sampler link
);
	logic [5:0] meta_q, meta_d;
	logic [5:0] sync_q, sync_d;
	logic [5:0] snap_q, snap_d;
	logic [11:0] tick_q, tick_d;
	logic change_q, change_d;
	logic [5:0] diff;

	always_comb begin
		meta_d = {sixth_id_input, id_pins};
		sync_d = meta_q;
		// every level is snapshotted so enabling the sixth input raises no false change
		diff = (sync_q ^ snap_q) & {link.sixth_enable, 5'h1F};
		tick_d = (tick_q == vid_pkg::ID_CHANGE_LAST) ? 12'h000 : tick_q + 12'h001;
		snap_d = snap_q;
		change_d = 1'b0;
		if (tick_q == vid_pkg::ID_CHANGE_LAST) begin
			// compare with the levels held one period earlier
			snap_d = sync_q; // see [R10]
			change_d = link.sixth_enable && (diff != 6'h00); // see [R10]
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 6'h00;
			sync_q <= 6'h00;
			snap_q <= 6'h00;
			tick_q <= 12'h000;
			change_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			snap_q <= snap_d;
			tick_q <= tick_d;
			change_q <= change_d;
		end
	end

	assign link.levels = sync_q;
	assign link.change = change_q;

	a_change_period: assert property (@(posedge clk) disable iff (!rst_b) // see [R10]
		change_q |-> tick_q == 12'h000) else $error("id change pulse off the sampling period");
	a_change_gated: assert property (@(posedge clk) disable iff (!rst_b) // see [R10]
		!link.sixth_enable |=> !change_q) else $error("id change pulse with sixth input off");
endmodule

// ==== hw/id_link_if.sv ====
// interface: synchronised id levels and change events between sampler and register
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface id_link_if;
	logic [5:0] levels;
	logic sixth_enable;
	logic change;
	modport sampler (output levels, output change, input sixth_enable);
	modport core (input levels, input change, output sixth_enable);
endinterface

// ==== hw/processor_voltage_id_register.sv ====
// top: processor voltage-id code register with shared pin role and supply code scaling
// assumes a byte register port from the serial engine, one clock, async pins
// What this block does
// [R1] bit 6 selects id input threshold: 0 is 1 V, 1 is 0.6 V
// [R2] bit 7 selects shared pin role: high supply or sixth id input; readable
// [R3] with role bit clear, bit 5 always reads zero
// [R4] with role bit set, bit 5 reads the shared pin level
// [R5] status 2 bit 0 shows supply limit or id change by role bit
// [R6] with shared pin as id input, no high supply measurement is made
// [R7] supply codes are 10-bit, saturate at 1023, nominal is 768
// [R8] own-supply channel uses 5 V scaling when config 1 option selects it
// [R9] bits 0 to 4 read the five dedicated id pin levels
// [R10] id change flag sets when levels differ from those 11 us earlier
// [R11] id change raises alert unless mask 2 bit 0 is set
// [R12] bits 6 and 7 writable and kept; bits 0 to 5 read-only
`timescale 1ns/1ps
module processor_voltage_id_register (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata_q,
	input wire logic [4:0] id_pins,
	input wire logic sixth_id_input,
	input wire logic supply_limit_event,
	input wire logic status2_clear,
	input wire logic id_change_mask,
	input wire logic cfg_supply_5v,
	input wire logic conv_valid,
	input wire logic conv_is_high_supply,
	input wire logic [11:0] conv_raw,
	output logic id_input_threshold_select_q,
	output logic shared_pin_role_select_q,
	output logic high_supply_measure_en_q,
	output logic supply_or_id_change_flag_q,
	output logic id_change_alert_q,
	output logic vcc_scale_5v_q,
	output logic supply_code_valid_q,
	output logic [9:0] supply_code_q
);
	id_link_if link ();

	id_input_sampler sampler (
		.clk(clk),
		.rst_b(rst_b),
		.id_pins(id_pins),
		.sixth_id_input(sixth_id_input),
		.link(link)
	);

	function automatic logic [9:0] saturate_code(input logic [11:0] raw);
		saturate_code = (raw > {2'b00, vid_pkg::CODE_MAX}) ? vid_pkg::CODE_MAX : raw[9:0];
	endfunction

	function automatic logic is_id_code_addr(input logic [7:0] addr);
		if (addr == vid_pkg::ID_CODE_ADDR) begin
			is_id_code_addr = 1'b1;
		end else begin
			is_id_code_addr = 1'b0;
		end
	endfunction

	logic hit_wr, hit_rd;
	logic [7:0] rdata_d;
	logic threshold_d, role_d, meas_d, flag_d, alert_d, scale_d, valid_d;
	logic [9:0] code_d;

	assign link.sixth_enable = shared_pin_role_select_q;

	always_comb begin
		hit_wr = reg_wr && is_id_code_addr(reg_addr);
		hit_rd = reg_rd && is_id_code_addr(reg_addr);
		threshold_d = id_input_threshold_select_q;
		role_d = shared_pin_role_select_q;
		if (hit_wr) begin
			// only the two control bits take the write
			threshold_d = reg_wdata[vid_pkg::THRESHOLD_BIT]; // see [R1] see [R12]
			role_d = reg_wdata[vid_pkg::ROLE_BIT]; // see [R2] see [R12]
		end
		rdata_d = reg_rdata_q;
		if (hit_rd) begin
			rdata_d = {shared_pin_role_select_q, id_input_threshold_select_q, // see [R2]
				shared_pin_role_select_q & link.levels[5], // see [R3] see [R4]
				link.levels[4:0]}; // see [R9]
		end else if (reg_rd) begin
			rdata_d = 8'h00;
		end
		meas_d = !shared_pin_role_select_q; // see [R6]
		flag_d = supply_or_id_change_flag_q;
		if (shared_pin_role_select_q ? link.change : supply_limit_event) begin
			flag_d = 1'b1; // see [R5] see [R10]
		end else if (status2_clear) begin
			flag_d = 1'b0;
		end
		if (role_d != shared_pin_role_select_q) begin
			flag_d = 1'b0;
		end
		alert_d = shared_pin_role_select_q && supply_or_id_change_flag_q && !id_change_mask; // see [R11]
		scale_d = cfg_supply_5v; // see [R8]
		valid_d = conv_valid && !(conv_is_high_supply && shared_pin_role_select_q); // see [R6]
		code_d = valid_d ? saturate_code(conv_raw) : supply_code_q; // see [R7]
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= vid_pkg::ID_CODE_RESET;
			id_input_threshold_select_q <= 1'b0;
			shared_pin_role_select_q <= 1'b0;
			high_supply_measure_en_q <= 1'b1;
			supply_or_id_change_flag_q <= 1'b0;
			id_change_alert_q <= 1'b0;
			vcc_scale_5v_q <= 1'b0;
			supply_code_valid_q <= 1'b0;
			supply_code_q <= 10'h000;
		end else begin
			reg_rdata_q <= rdata_d;
			id_input_threshold_select_q <= threshold_d;
			shared_pin_role_select_q <= role_d;
			high_supply_measure_en_q <= meas_d;
			supply_or_id_change_flag_q <= flag_d;
			id_change_alert_q <= alert_d;
			vcc_scale_5v_q <= scale_d;
			supply_code_valid_q <= valid_d;
			supply_code_q <= code_d;
		end
	end

	a_threshold_write: assert property (@(posedge clk) disable iff (!rst_b) // see [R1]
		hit_wr |=> id_input_threshold_select_q == $past(reg_wdata[6])) else $error("threshold bit not stored");
	a_role_write: assert property (@(posedge clk) disable iff (!rst_b) // see [R2]
		hit_wr ##1 !hit_wr ##1 hit_rd |=> reg_rdata_q[7] == $past(reg_wdata[7], 3))
		else $error("role bit not read back");
	a_bit5_zero: assert property (@(posedge clk) disable iff (!rst_b) // see [R3]
		hit_rd && !shared_pin_role_select_q |=> reg_rdata_q[5] == 1'b0) else $error("bit 5 not zero");
	a_bit5_follow: assert property (@(posedge clk) disable iff (!rst_b) // see [R4]
		hit_rd && shared_pin_role_select_q |=> reg_rdata_q[5] == $past(link.levels[5]))
		else $error("bit 5 does not follow shared pin");
	a_low_bits: assert property (@(posedge clk) disable iff (!rst_b) // see [R9]
		hit_rd |=> reg_rdata_q[4:0] == $past(link.levels[4:0])) else $error("id bits wrong");
	a_flag_supply: assert property (@(posedge clk) disable iff (!rst_b) // see [R5]
		!shared_pin_role_select_q && supply_limit_event && !hit_wr |=> supply_or_id_change_flag_q)
		else $error("supply limit not flagged");
	a_flag_change: assert property (@(posedge clk) disable iff (!rst_b) // see [R10]
		shared_pin_role_select_q && link.change && !hit_wr |=> supply_or_id_change_flag_q ##1 id_change_alert_q
		|| $past(id_change_mask)) else $error("id change not flagged");
	a_no_high_meas: assert property (@(posedge clk) disable iff (!rst_b) // see [R6]
		conv_valid && conv_is_high_supply && shared_pin_role_select_q |=> !supply_code_valid_q && !high_supply_measure_en_q)
		else $error("high supply measured in id mode");
	a_code_sat: assert property (@(posedge clk) disable iff (!rst_b) // see [R7]
		conv_valid && !conv_is_high_supply && conv_raw > 12'h3FF |=> supply_code_q == 10'h3FF)
		else $error("code not saturated");
	a_alert_mask: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
		id_change_mask |=> !id_change_alert_q) else $error("masked alert raised");
	a_vcc_scale: assert property (@(posedge clk) disable iff (!rst_b) // see [R8]
		$rose(cfg_supply_5v) |=> vcc_scale_5v_q) else $error("5 V scaling not selected");

	a_role_store: assert property (@(posedge clk) disable iff (!rst_b) // see [R2]
		hit_wr |=> shared_pin_role_select_q == $past(reg_wdata[vid_pkg::ROLE_BIT]))
		else $error("role bit not stored");

	a_threshold_keep: assert property (@(posedge clk) disable iff (!rst_b) // see [R12]
		!hit_wr |=> $stable(id_input_threshold_select_q))
		else $error("threshold bit changed without a write");

	a_role_keep: assert property (@(posedge clk) disable iff (!rst_b) // see [R12]
		!hit_wr |=> $stable(shared_pin_role_select_q))
		else $error("role bit changed without a write");

	a_threshold_readback: assert property (@(posedge clk) disable iff (!rst_b) // see [R1]
		hit_rd |=> reg_rdata_q[vid_pkg::THRESHOLD_BIT] == $past(id_input_threshold_select_q))
		else $error("threshold bit not read back");

	a_role_readback: assert property (@(posedge clk) disable iff (!rst_b) // see [R2]
		hit_rd |=> reg_rdata_q[vid_pkg::ROLE_BIT] == $past(shared_pin_role_select_q))
		else $error("role bit read back wrong");

	a_meas_stop: assert property (@(posedge clk) disable iff (!rst_b) // see [R6]
		shared_pin_role_select_q |=> !high_supply_measure_en_q)
		else $error("high supply measurement left on");

	a_meas_resume: assert property (@(posedge clk) disable iff (!rst_b) // see [R6]
		!shared_pin_role_select_q |=> high_supply_measure_en_q)
		else $error("high supply measurement off in supply mode");

	a_flag_clear: assert property (@(posedge clk) disable iff (!rst_b) // see [R5]
		status2_clear && !supply_limit_event && !link.change |=> !supply_or_id_change_flag_q)
		else $error("flag not cleared");

	a_supply_mux: assert property (@(posedge clk) disable iff (!rst_b) // see [R5]
		!shared_pin_role_select_q && !supply_limit_event && !supply_or_id_change_flag_q
		|=> !supply_or_id_change_flag_q)
		else $error("flag set in supply mode without a limit event");

	a_change_mux: assert property (@(posedge clk) disable iff (!rst_b) // see [R5]
		shared_pin_role_select_q && !link.change && !supply_or_id_change_flag_q
		|=> !supply_or_id_change_flag_q)
		else $error("flag set in id mode without an id change");

	a_alert_raise: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
		shared_pin_role_select_q && supply_or_id_change_flag_q && !id_change_mask |=> id_change_alert_q)
		else $error("unmasked id change gave no alert");

	a_alert_source: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
		id_change_alert_q |-> $past(supply_or_id_change_flag_q) && $past(shared_pin_role_select_q))
		else $error("alert without a flagged id change");

	a_alert_idle: assert property (@(posedge clk) disable iff (!rst_b) // see [R11]
		!shared_pin_role_select_q |=> !id_change_alert_q)
		else $error("id change alert in supply mode");

	a_code_pass: assert property (@(posedge clk) disable iff (!rst_b) // see [R7]
		conv_valid && !conv_is_high_supply && conv_raw <= 12'h3FF |=> supply_code_q == $past(conv_raw[9:0]))
		else $error("in-range code altered");

	a_high_sat: assert property (@(posedge clk) disable iff (!rst_b) // see [R7]
		conv_valid && conv_is_high_supply && !shared_pin_role_select_q && conv_raw > 12'h3FF
		|=> supply_code_q == 10'h3FF)
		else $error("high supply code not saturated");

	a_code_hold: assert property (@(posedge clk) disable iff (!rst_b) // see [R7]
		!conv_valid |=> !supply_code_valid_q && $stable(supply_code_q))
		else $error("supply code changed without a result");

	a_code_accept: assert property (@(posedge clk) disable iff (!rst_b) // see [R6]
		conv_valid && !(conv_is_high_supply && shared_pin_role_select_q) |=> supply_code_valid_q)
		else $error("accepted result not flagged valid");

	a_vcc_default: assert property (@(posedge clk) disable iff (!rst_b) // see [R8]
		!cfg_supply_5v |=> !vcc_scale_5v_q)
		else $error("5 V scaling without the option");
endmodule

// ==== hw/vid_pkg.sv ====
// package: constants for the processor voltage-id code register
// assumes a 200 MHz core clock and a byte-wide register port
package vid_pkg;
	localparam logic [7:0] ID_CODE_ADDR = 8'h43;
	localparam logic [7:0] ID_CODE_RESET = 8'h00;
	localparam int ROLE_BIT = 7;
	localparam int THRESHOLD_BIT = 6;
	localparam int SIXTH_BIT = 5;
	localparam int ID_PINS = 5;
	localparam int ID_WIDTH = 6;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int ID_CHANGE_TIME_NS = 11000;
	localparam int ID_CHANGE_CYCLES = ID_CHANGE_TIME_NS * 1000 / CLK_PERIOD_PS;
	localparam logic [11:0] ID_CHANGE_LAST = 12'(ID_CHANGE_CYCLES - 1);
	localparam int CODE_WIDTH = 10;
	localparam int RAW_WIDTH = 12;
	localparam logic [9:0] CODE_MAX = 10'h3FF;
	localparam logic [9:0] CODE_NOMINAL = 10'h300;
endpackage

// ==== test/host_model.sv ====
// host model: issues single-byte register writes and reads
// assumes the block samples its strobes on the rising edge of clk
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	output logic [7:0] addr,
	output logic wr,
	output logic rd,
	output logic [7:0] wdata
);
	initial begin
		addr = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		wdata = 8'h00;
	end
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
		wdata = ~d;
	endtask
	task automatic get(input logic [7:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
	endtask
endmodule

// ==== test/processor_voltage_id_register_tb_top.sv ====
// testbench: register, id change, status flag and supply code scenarios
// assumes host_model drives the register port
`timescale 1ns/1ps
module processor_voltage_id_register_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] addr, wdata, rdata;
	logic wr, rd, thresh, role, hen, flag, alert, sc5, scv;
	logic [4:0] pins = 5'h15;
	logic sixth = 1'b1, lim = 1'b0, clr = 1'b0, mask = 1'b0, v5 = 1'b0, cv = 1'b0, chs = 1'b0;
	logic [11:0] raw = 12'h000;
	logic [9:0] code;
	int failures = 0, total_checks = 0, cyc = 0;
	host_model u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));
	processor_voltage_id_register u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wdata), .reg_rdata_q(rdata), .id_pins(pins), .sixth_id_input(sixth),
		.supply_limit_event(lim), .status2_clear(clr), .id_change_mask(mask), .cfg_supply_5v(v5),
		.conv_valid(cv), .conv_is_high_supply(chs), .conv_raw(raw), .id_input_threshold_select_q(thresh),
		.shared_pin_role_select_q(role), .high_supply_measure_en_q(hen),
		.supply_or_id_change_flag_q(flag), .id_change_alert_q(alert), .vcc_scale_5v_q(sc5),
		.supply_code_valid_q(scv), .supply_code_q(code));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		u_host.get(a);
		chk("rdata", 12'(e), 12'(rdata));
	endtask
	task automatic conv(input logic h, input logic [11:0] r, input logic v, input logic [9:0] e);
		@(negedge clk);
		cv = 1'b1;
		chs = h;
		raw = r;
		@(negedge clk);
		cv = 1'b0;
		chk("code valid", 12'(v), 12'(scv));
		if (v) chk("code", 12'(e), 12'(code));
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		@(negedge clk);
	endtask
	task automatic t_regs();
		rdchk(8'h43, 8'h15);
		chk("measure en", 12'h001, 12'(hen));
		u_host.put(8'h43, 8'h7F);
		rdchk(8'h43, 8'h55);
		chk("threshold", 12'h001, 12'(thresh));
		u_host.put(8'h43, 8'hBF);
		rdchk(8'h43, 8'hB5);
		chk("role", 12'h001, 12'(role));
		chk("measure en", 12'h000, 12'(hen));
		rdchk(8'h44, 8'h00);
	endtask
	task automatic t_conv();
		conv(1'b1, 12'h100, 1'b0, 10'h000);
		conv(1'b0, 12'h500, 1'b1, 10'h3FF);
		conv(1'b0, 12'h300, 1'b1, 10'h300);
	endtask
	task automatic t_change();
		int n;
		n = 0;
		pins = 5'h0A;
		sixth = 1'b0;
		while (flag !== 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		chk("id change flag", 12'h001, 12'(flag));
		rdchk(8'h43, 8'h8A);
		chk("alert", 12'h001, 12'(alert));
		mask = 1'b1;
		repeat (2) @(negedge clk);
		chk("masked alert", 12'h000, 12'(alert));
		chk("flag held", 12'h001, 12'(flag));
		pulse(clr);
		chk("flag clear", 12'h000, 12'(flag));
	endtask
	task automatic t_limit();
		u_host.put(8'h43, 8'h00);
		pins = 5'h15;
		sixth = 1'b1;
		repeat (4500) @(negedge clk);
		chk("supply mode flag", 12'h000, 12'(flag));
		rdchk(8'h43, 8'h15);
		pulse(lim);
		chk("limit flag", 12'h001, 12'(flag));
		chk("vcc scale", 12'h000, 12'(sc5));
		v5 = 1'b1;
		repeat (2) @(negedge clk);
		chk("vcc scale", 12'h001, 12'(sc5));
	endtask
	task automatic finish_test();
		if (failures == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (3) @(negedge clk);
		t_regs();
		t_conv();
		t_change();
		t_limit();
		finish_test();
	end
endmodule
